// File: include/rvs_pkg.sv
// constants, types and helpers for the receive-port remap and stats block
// Functional notes
// - remap only while input format is CSI-2
// - replace channel id via remap entry; reset 0xE4
// - remap fields [7:6] ch3 down to [1:0] ch0
// - register access only when port selected
// - frame line count 16 bit at 0x73/0x74
// - line count frozen until read when enabled
// - upper byte read latches lower line-count byte
// - line width 16 bit at 0x75/0x76
// - line width is that of last line
// - line width frozen until read when enabled
// - upper byte read latches lower width byte
// - format code 00 is CSI-2, rest RAW
package rvs_pkg;

    // register offsets
    localparam logic [7:0]  ADDR_CHANNEL_REMAP = 8'h72;
    localparam logic [7:0]  ADDR_LINES_UPPER   = 8'h73;
    localparam logic [7:0]  ADDR_LINES_LOWER   = 8'h74;
    localparam logic [7:0]  ADDR_WIDTH_UPPER   = 8'h75;
    localparam logic [7:0]  ADDR_WIDTH_LOWER   = 8'h76;

    // reset values and read answers
    localparam logic [7:0]  REMAP_RESET    = 8'he4;
    localparam logic [15:0] STAT_RESET     = 16'h0000;
    localparam logic [7:0]  RDATA_NONE     = 8'h00;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] COUNT_ONE      = 16'h0001;

    // field layout
    localparam int          REMAP_FIELD_W  = 2;
    localparam int          PORT_CNT       = 4;

    // input format codes
    localparam logic [1:0]  FMT_CSI2       = 2'h0;
    localparam logic [1:0]  FMT_RAW12_LF   = 2'h1;
    localparam logic [1:0]  FMT_RAW12_HF   = 2'h2;
    localparam logic [1:0]  FMT_RAW10      = 2'h3;

    // packet data types
    localparam logic [5:0]  DT_FRAME_START = 6'h00;
    localparam logic [5:0]  DT_FRAME_END   = 6'h01;
    localparam logic [5:0]  DT_LONG_MIN    = 6'h10;

    // one packet header as it travels the stream
    typedef struct packed {
        logic [1:0]  vc;
        logic [5:0]  dt;
        logic [15:0] wc;
    } rvs_pkt_t;

    // one register access from the host-side target
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } rvs_reg_req_t;

    // measurement sequencer states
    typedef enum logic [1:0] {
        RVS_ST_HUNT  = 2'h1,
        RVS_ST_FRAME = 2'h2
    } rvs_state_t;

    function automatic logic rvs_is_fs(input rvs_pkt_t p);
        rvs_is_fs = (p.dt == DT_FRAME_START);
    endfunction : rvs_is_fs

    function automatic logic rvs_is_fe(input rvs_pkt_t p);
        rvs_is_fe = (p.dt == DT_FRAME_END);
    endfunction : rvs_is_fe

    function automatic logic rvs_is_line(input rvs_pkt_t p);
        rvs_is_line = (p.dt >= DT_LONG_MIN);
    endfunction : rvs_is_line

    // pick the replacement id for an original channel
    function automatic logic [1:0] rvs_remap_vc(input logic [7:0] map,
                                                input logic [1:0] vc);
        rvs_remap_vc = map[int'(vc) * REMAP_FIELD_W +: REMAP_FIELD_W];
    endfunction : rvs_remap_vc

endpackage : rvs_pkg

// File: rtl/rvs_buf.sv
// two-entry packet buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rvs_buf
    import rvs_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rstn,
    input  wire logic     in_valid,
    input  wire rvs_pkt_t in_pkt,
    output logic          in_ready,
    output logic          out_valid,
    output rvs_pkt_t      out_pkt,
    input  wire logic     out_ready
);

    logic     skid_valid;
    rvs_pkt_t skid_pkt;
    logic     next_out_valid;
    rvs_pkt_t next_out_pkt;
    logic     next_skid_valid;
    rvs_pkt_t next_skid_pkt;

    // full means the skid entry is taken; the source then stalls
    assign in_ready = !skid_valid;

    // head entry drives the output, second entry catches a stalled word
    always_comb begin
        next_out_valid  = out_valid;
        next_out_pkt    = out_pkt;
        next_skid_valid = skid_valid;
        next_skid_pkt   = skid_pkt;
        if (out_ready || !out_valid) begin
            if (skid_valid) begin
                next_out_valid  = 1'b1;
                next_out_pkt    = skid_pkt;
                next_skid_valid = 1'b0;
            end else begin
                next_out_valid = in_valid;
                next_out_pkt   = in_pkt;
            end
        end else if (in_valid && in_ready) begin
            next_skid_valid = 1'b1;
            next_skid_pkt   = in_pkt;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out_valid  <= 1'b0;
            out_pkt    <= '0;
            skid_valid <= 1'b0;
            skid_pkt   <= '0;
        end else begin
            out_valid  <= next_out_valid;
            out_pkt    <= next_out_pkt;
            skid_valid <= next_skid_valid;
            skid_pkt   <= next_skid_pkt;
        end
    end

endmodule : rvs_buf
`default_nettype wire

// File: rtl/rvs_split_stat.sv
// 16-bit statistic with freeze-until-read and upper-byte read latching
`timescale 1ns/10ps
`default_nettype none
module rvs_split_stat
    import rvs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        upd,
    input  wire logic [15:0] upd_val,
    input  wire logic        freeze_en,
    input  wire logic        rd_upper,
    input  wire logic        rd_lower,
    output logic      [7:0]  upper_byte,
    output logic      [7:0]  lower_byte,
    output logic             changed
);

    logic [15:0] value;
    logic        held;
    logic [7:0]  lower_hold;
    logic        hold_valid;
    logic [15:0] next_value;
    logic        next_held;
    logic [7:0]  next_lower_hold;
    logic        next_hold_valid;
    logic        next_changed;
    logic        accept;

    // a frozen value ignores fresh measurements until the host reads it
    assign accept     = upd && !(freeze_en && held);
    assign upper_byte = value[15:8];
    // after an upper read the lower half comes from the held copy
    assign lower_byte = hold_valid ? lower_hold : value[7:0];

    always_comb begin
        next_value      = value;
        next_held       = held;
        next_lower_hold = lower_hold;
        next_hold_valid = hold_valid;
        next_changed    = 1'b0;
        // any read releases the freeze
        if (rd_upper || rd_lower) begin
            next_held = 1'b0;
        end
        if (accept) begin
            next_value = upd_val;
            if (upd_val != value) begin
                next_changed = freeze_en;
                // set wins over a read in the same cycle
                next_held    = freeze_en;
            end
        end
        if (rd_upper) begin
            next_lower_hold = value[7:0];
            next_hold_valid = 1'b1;
        end else if (rd_lower) begin
            next_hold_valid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            value      <= STAT_RESET;
            held       <= 1'b0;
            lower_hold <= STAT_RESET[7:0];
            hold_valid <= 1'b0;
            changed    <= 1'b0;
        end else begin
            value      <= next_value;
            held       <= next_held;
            lower_hold <= next_lower_hold;
            hold_valid <= next_hold_valid;
            changed    <= next_changed;
        end
    end

endmodule : rvs_split_stat
`default_nettype wire

// File: rtl/rvs_rx_port.sv
// receive port: channel remap on the packet stream and frame statistics
`timescale 1ns/10ps
`default_nettype none
module rvs_rx_port
    import rvs_pkg::*;
#(
    parameter int PORT_NUM = 0
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    // port selection mask from the shared selector register
    input  wire logic [3:0]  port_select,
    // register access from the host-side target
    input  wire rvs_reg_req_t reg_req,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // port-level configuration held elsewhere
    input  wire logic [1:0]  input_format_select,
    input  wire logic        lines_changed_irq_enable,
    input  wire logic        width_changed_irq_enable,
    // incoming packet stream from the link
    input  wire logic        in_valid,
    input  wire rvs_pkt_t    in_pkt,
    output logic             in_ready,
    // outgoing packet stream toward the aggregator
    output logic             out_valid,
    output rvs_pkt_t         out_pkt,
    input  wire logic        out_ready,
    // change events toward the interrupt logic
    output logic             lines_changed_event,
    output logic             width_changed_event
);

    // ------------------------------------------------------------
    // register access signals
    // ------------------------------------------------------------
    logic        port_hit;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  channel_remap;
    logic [7:0]  next_channel_remap;
    logic [7:0]  next_reg_rdata;
    logic        next_reg_rvalid;
    logic        rd_lines_upper;
    logic        rd_lines_lower;
    logic        rd_width_upper;
    logic        rd_width_lower;

    // byte views from the two statistics
    logic [7:0]  frame_lines_upper_byte;
    logic [7:0]  frame_lines_lower_byte;
    logic [7:0]  line_width_upper_byte;
    logic [7:0]  line_width_lower_byte;

    // ------------------------------------------------------------
    // stream signals
    // ------------------------------------------------------------
    logic        csi_mode;
    logic        take;
    rvs_pkt_t    mapped_pkt;

    // ------------------------------------------------------------
    // measurement signals
    // ------------------------------------------------------------
    rvs_state_t  state;
    rvs_state_t  next_state;
    logic [15:0] line_cnt;
    logic [15:0] next_line_cnt;
    logic [15:0] last_width;
    logic [15:0] next_last_width;
    logic        upd;
    logic        next_upd;
    logic [15:0] upd_lines;
    logic [15:0] next_upd_lines;
    logic [15:0] upd_width;
    logic [15:0] next_upd_width;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------

    // only the selected port answers; another port's copy stays quiet
    assign port_hit = port_select[PORT_NUM];
    assign wr_hit   = reg_req.wr && port_hit;
    assign rd_hit   = reg_req.rd && port_hit;

    // read strobes that carry side effects inside the statistics
    assign rd_lines_upper = rd_hit && (reg_req.addr == ADDR_LINES_UPPER);
    assign rd_lines_lower = rd_hit && (reg_req.addr == ADDR_LINES_LOWER);
    assign rd_width_upper = rd_hit && (reg_req.addr == ADDR_WIDTH_UPPER);
    assign rd_width_lower = rd_hit && (reg_req.addr == ADDR_WIDTH_LOWER);

    // next values of the register group
    always_comb begin
        next_channel_remap = channel_remap;
        next_reg_rdata     = reg_rdata;
        next_reg_rvalid    = 1'b0;
        // writes to read-only offsets are dropped without trace
        if (wr_hit && (reg_req.addr == ADDR_CHANNEL_REMAP)) begin
            next_channel_remap = reg_req.wdata;
        end
        if (rd_hit) begin
            next_reg_rvalid = 1'b1;
            unique case (reg_req.addr)
                ADDR_CHANNEL_REMAP: begin
                    next_reg_rdata = channel_remap;
                end
                ADDR_LINES_UPPER: begin
                    next_reg_rdata = frame_lines_upper_byte;
                end
                ADDR_LINES_LOWER: begin
                    next_reg_rdata = frame_lines_lower_byte;
                end
                ADDR_WIDTH_UPPER: begin
                    next_reg_rdata = line_width_upper_byte;
                end
                ADDR_WIDTH_LOWER: begin
                    next_reg_rdata = line_width_lower_byte;
                end
                default: begin
                    // offsets outside this block read as zero
                    next_reg_rdata = RDATA_NONE;
                end
            endcase
        end
    end

    // register group storage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            channel_remap <= REMAP_RESET;
            reg_rdata     <= RDATA_NONE;
            reg_rvalid    <= 1'b0;
        end else begin
            channel_remap <= next_channel_remap;
            reg_rdata     <= next_reg_rdata;
            reg_rvalid    <= next_reg_rvalid;
        end
    end

    // ------------------------------------------------------------
    // channel remap
    // ------------------------------------------------------------

    // raw formats carry their channel from elsewhere, so pass untouched
    assign csi_mode = (input_format_select == FMT_CSI2);

    // rewrite the channel id as the header enters the buffer
    always_comb begin
        mapped_pkt = in_pkt;
        if (csi_mode) begin
            // two-bit fields, channel 3 in the top pair
            mapped_pkt.vc = rvs_remap_vc(channel_remap, in_pkt.vc);
        end
    end

    // a stall downstream holds the header in the buffer, none is lost
    rvs_buf u_buf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (in_valid),
        .in_pkt    (mapped_pkt),
        .in_ready  (in_ready),
        .out_valid (out_valid),
        .out_pkt   (out_pkt),
        .out_ready (out_ready)
    );

    // measurement only sees headers the buffer really took
    assign take = in_valid && in_ready;

    // ------------------------------------------------------------
    // frame measurement
    // ------------------------------------------------------------

    // count lines between frame start and end, keep the last width
    always_comb begin
        next_state      = state;
        next_line_cnt   = line_cnt;
        next_last_width = last_width;
        next_upd        = 1'b0;
        next_upd_lines  = upd_lines;
        next_upd_width  = upd_width;
        unique case (state)
            RVS_ST_HUNT: begin
                // nothing counts until a frame has begun
                if (take && rvs_is_fs(in_pkt)) begin
                    next_state      = RVS_ST_FRAME;
                    next_line_cnt   = STAT_RESET;
                    next_last_width = STAT_RESET;
                end
            end
            RVS_ST_FRAME: begin
                if (take) begin
                    if (rvs_is_fs(in_pkt)) begin
                        // a lost frame end restarts the count
                        next_line_cnt   = STAT_RESET;
                        next_last_width = STAT_RESET;
                    end else if (rvs_is_fe(in_pkt)) begin
                        next_state     = RVS_ST_HUNT;
                        next_upd       = 1'b1;
                        next_upd_lines = line_cnt;
                        next_upd_width = last_width;
                    end else if (rvs_is_line(in_pkt)) begin
                        // saturate instead of wrapping on huge frames
                        if (line_cnt != COUNT_MAX) begin
                            next_line_cnt = 16'(line_cnt + COUNT_ONE);
                        end
                        // each line overwrites, so the last one stays
                        next_last_width = in_pkt.wc;
                    end
                end
            end
        endcase
    end

    // measurement storage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state      <= RVS_ST_HUNT;
            line_cnt   <= STAT_RESET;
            last_width <= STAT_RESET;
            upd        <= 1'b0;
            upd_lines  <= STAT_RESET;
            upd_width  <= STAT_RESET;
        end else begin
            state      <= next_state;
            line_cnt   <= next_line_cnt;
            last_width <= next_last_width;
            upd        <= next_upd;
            upd_lines  <= next_upd_lines;
            upd_width  <= next_upd_width;
        end
    end

    // ------------------------------------------------------------
    // reported statistics
    // ------------------------------------------------------------

    // line count of the latest frame
    rvs_split_stat u_lines (
        .mclk       (mclk),
        .rstn       (rstn),
        .upd        (upd),
        .upd_val    (upd_lines),
        .freeze_en  (lines_changed_irq_enable),
        .rd_upper   (rd_lines_upper),
        .rd_lower   (rd_lines_lower),
        .upper_byte (frame_lines_upper_byte),
        .lower_byte (frame_lines_lower_byte),
        .changed    (lines_changed_event)
    );

    // width of the last line of the latest frame
    rvs_split_stat u_width (
        .mclk       (mclk),
        .rstn       (rstn),
        .upd        (upd),
        .upd_val    (upd_width),
        .freeze_en  (width_changed_irq_enable),
        .rd_upper   (rd_width_upper),
        .rd_lower   (rd_width_lower),
        .upper_byte (line_width_upper_byte),
        .lower_byte (line_width_lower_byte),
        .changed    (width_changed_event)
    );

endmodule : rvs_rx_port
`default_nettype wire

// File: sim/rvs_rx_port_sva.sv
// concurrent checks on the receive-port remap and stats ports
`timescale 1ns/10ps
`default_nettype none
module rvs_chk
    import rvs_pkg::*;
#(
    parameter int PORT_NUM = 0
) (
    input wire logic         mclk,
    input wire logic         rstn,
    input wire logic [3:0]   port_select,
    input wire rvs_reg_req_t reg_req,
    input wire logic [7:0]   reg_rdata,
    input wire logic         reg_rvalid,
    input wire logic [1:0]   input_format_select,
    input wire logic         lines_changed_irq_enable,
    input wire logic         width_changed_irq_enable,
    input wire logic         in_valid,
    input wire rvs_pkt_t     in_pkt,
    input wire logic         in_ready,
    input wire logic         out_valid,
    input wire rvs_pkt_t     out_pkt,
    input wire logic         out_ready,
    input wire logic         lines_changed_event,
    input wire logic         width_changed_event
);
    logic       sel, rd_l, rd_w, take, frz_l, next_frz_l, frz_w, next_frz_w;
    logic [1:0] mapped;
    logic [7:0] shadow, next_shadow;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // shadow map and freeze flags; a read beats a visible event because
    // the design froze on the same edge the event showed
    always_comb begin
        sel         = port_select[PORT_NUM];
        rd_l        = sel && reg_req.rd && reg_req.addr inside {8'h73, 8'h74};
        rd_w        = sel && reg_req.rd && reg_req.addr inside {8'h75, 8'h76};
        take        = in_valid && in_ready && !out_valid;
        mapped      = shadow[{in_pkt.vc, 1'b0} +: 2];
        next_shadow = shadow;
        if (sel && reg_req.wr && reg_req.addr == ADDR_CHANNEL_REMAP) begin
            next_shadow = reg_req.wdata;
        end
        next_frz_l  = rd_l ? 1'b0 : (lines_changed_event | frz_l);
        next_frz_w  = rd_w ? 1'b0 : (width_changed_event | frz_w);
    end

    // registers of the helper state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shadow <= REMAP_RESET;
            frz_l  <= 1'b0;
            frz_w  <= 1'b0;
        end else begin
            shadow <= next_shadow;
            frz_l  <= next_frz_l;
            frz_w  <= next_frz_w;
        end
    end

    rd_answer_a: assert property (
        sel && reg_req.rd |=> reg_rvalid) else $error("read not answered");
    unsel_quiet_a: assert property (
        reg_rvalid |-> $past(sel && reg_req.rd)) else $error("stray answer");
    unmapped_zero_a: assert property (
        sel && reg_req.rd && !(reg_req.addr inside {[8'h72:8'h76]})
        |=> reg_rdata == RDATA_NONE) else $error("unmapped read not zero");
    remap_read_a: assert property (
        sel && reg_req.rd && reg_req.addr == ADDR_CHANNEL_REMAP
        |=> reg_rdata == $past(shadow)) else $error("map readback wrong");
    raw_pass_a: assert property (
        take && input_format_select != FMT_CSI2
        |=> out_valid && out_pkt == $past(in_pkt)) else $error("raw altered");
    csi_remap_a: assert property (
        take && input_format_select == FMT_CSI2 |=> out_valid
        && out_pkt.vc == $past(mapped) && out_pkt.wc == $past(in_pkt.wc))
        else $error("channel not remapped");
    lines_frozen_a: assert property (
        frz_l |-> !lines_changed_event) else $error("line count not frozen");
    width_frozen_a: assert property (
        frz_w |-> !width_changed_event) else $error("width not frozen");
    event_gated_a: assert property (
        !(lines_changed_event && !$past(lines_changed_irq_enable))
        && !(width_changed_event && !$past(width_changed_irq_enable)))
        else $error("event while disabled");
    ready_free_a: assert property (!out_valid |-> in_ready)
        else $error("input refused while empty");

    cover property (take && input_format_select == FMT_CSI2);
    cover property (lines_changed_event ##[1:20] rd_l);
    cover property (out_valid && !out_ready ##1 out_ready);
endmodule : rvs_chk

bind rvs_rx_port rvs_chk #(.PORT_NUM(PORT_NUM)) chk_u (
    .mclk, .rstn, .port_select, .reg_req, .reg_rdata, .reg_rvalid,
    .input_format_select, .lines_changed_irq_enable,
    .width_changed_irq_enable, .in_valid, .in_pkt, .in_ready, .out_valid,
    .out_pkt, .out_ready, .lines_changed_event, .width_changed_event
);
`default_nettype wire

// File: sim/rvs_src_model.sv
// packet source standing for the remote serializer
`timescale 1ns/10ps
`default_nettype none
module rvs_src
    import rvs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic in_ready,
    output var logic  in_valid,
    output var rvs_pkt_t in_pkt
);
    // quiet lines at time zero
    initial begin
        in_valid = 1'b0;
        in_pkt   = '0;
    end

    // offer at the falling edge, hold until a rising edge takes it
    task automatic send(input rvs_pkt_t p);
        @(negedge mclk);
        in_valid = 1'b1;
        in_pkt   = p;
        #1;
        while (!in_ready) begin
            @(negedge mclk);
            #1;
        end
        @(posedge mclk);
    endtask : send

    // released lines show the inverse so stale headers are never trusted
    task automatic idle();
        @(negedge mclk);
        in_valid = 1'b0;
        in_pkt   = ~in_pkt;
    endtask : idle
endmodule : rvs_src
`default_nettype wire

// File: sim/rvs_rx_port_tb_top.sv
// self-checking bench for the receive-port remap and stats block
`timescale 1ns/10ps
`default_nettype none
module rvs_rx_port_tb_top
    import rvs_pkg::*;
;
    localparam int PN = 2;
    logic         mclk, rstn, in_valid, in_ready, out_valid, out_ready;
    logic         reg_rvalid, l_en, w_en, ev_l, ev_w;
    logic [1:0]   fmt;
    logic [3:0]   port_select;
    logic [7:0]   reg_rdata, map, a;
    logic [15:0]  rnd, rs;
    rvs_reg_req_t reg_req;
    rvs_pkt_t     in_pkt, out_pkt;
    rvs_pkt_t     exp_q[$];
    int           rep[2], hold[2], nev[2], sev[2], frz[2], f, v;
    int           miscompares, num_checks;

    rvs_rx_port #(.PORT_NUM(PN)) dut_u (
        .mclk(mclk), .rstn(rstn), .port_select(port_select),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .input_format_select(fmt), .lines_changed_irq_enable(l_en),
        .width_changed_irq_enable(w_en), .in_valid(in_valid),
        .in_pkt(in_pkt), .in_ready(in_ready), .out_valid(out_valid),
        .out_pkt(out_pkt), .out_ready(out_ready),
        .lines_changed_event(ev_l), .width_changed_event(ev_w));
    rvs_src src_u (.mclk(mclk), .in_ready(in_ready), .in_valid(in_valid),
        .in_pkt(in_pkt));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string what, input logic [23:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // one register access; expectation taken from the model first
    task automatic acc(input logic w, input logic [7:0] ad, d);
        logic [7:0] e;
        int         k;
        logic       sel;
        sel = port_select[PN];
        k   = int'(ad - 8'h73) / 2;
        e   = RDATA_NONE;
        if (sel && w && ad == ADDR_CHANNEL_REMAP) map = d;
        if (sel && !w && ad == ADDR_CHANNEL_REMAP) e = map;
        if (sel && !w && ad inside {[8'h73:8'h76]}) begin
            if (ad[0]) begin
                e       = 8'(rep[k] >> 8);
                hold[k] = rep[k] & 255;
            end else begin
                e       = 8'(hold[k] >= 0 ? hold[k] : rep[k]);
                hold[k] = -1;
            end
            frz[k] = 0;
        end
        @(negedge mclk);
        reg_req = '{w, !w, ad, d};
        @(negedge mclk);
        reg_req = '0;
        if (!w) begin
            check("reg_rvalid", 24'(reg_rvalid), 24'(sel));
            if (sel) check("reg_rdata", 24'(reg_rdata), 24'(e));
        end
    endtask : acc

    // push the expected header, then let the source offer it
    task automatic put(input int vc, input logic [5:0] dt,
                       input logic [15:0] wc);
        rvs_pkt_t p;
        p.vc = 2'(vc);
        p.dt = dt;
        p.wc = wc;
        exp_q.push_back('{fmt == FMT_CSI2 ? map[2*vc +: 2] : p.vc, dt, wc});
        src_u.send(p);
    endtask : put

    // model update at frame end: frozen values drop newer measurements
    task automatic upd(input int k, input int val, input logic en);
        if (!frz[k]) begin
            if (en && val != rep[k]) begin
                frz[k] = 1;
                nev[k]++;
            end
            rep[k] = val;
        end
    endtask : upd

    task automatic frame(input int nl, input logic [15:0] last);
        int i;
        put(0, DT_FRAME_START, 16'h0000);
        for (i = 0; i < nl; i++) begin
            rnd = lfsr(rnd);
            put(i % 4, 6'h2b, i == nl - 1 ? last : rnd);
        end
        put(0, DT_FRAME_END, 16'h0000);
        src_u.idle();
        repeat (4) @(negedge mclk);
        upd(0, nl, l_en);
        upd(1, last, w_en);
    endtask : frame

    // clock, random receiver stall and count of event pulses
    always #5 mclk = ~mclk;
    always @(negedge mclk) begin
        rs = lfsr(rs);
        out_ready = rs[0] | rs[3];
    end
    always @(posedge mclk) begin
        if (ev_l === 1'b1) sev[0]++;
        if (ev_w === 1'b1) sev[1]++;
        if (rstn && out_valid && out_ready) begin
            check("out_pkt", out_pkt, exp_q.pop_front());
        end
    end

    // watchdog sized well above the expected run
    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        mclk = 0; rstn = 0; out_ready = 0; reg_req = '0; fmt = FMT_CSI2;
        l_en = 0; w_en = 0; port_select = 4'h4; map = REMAP_RESET;
        rnd = 16'h3a15; rs = 16'h3a15; hold = '{-1, -1};
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rstn = 1;
        // reset values, an unmapped offset and a refused write
        for (a = 8'h72; a <= 8'h77; a++) acc(0, a, 0);
        acc(1, 8'h73, 8'h5a);
        acc(0, 8'h73, 0);
        // a deselected port is written and then read; only the missing answer is checked
        port_select = ~4'h4;
        acc(1, ADDR_CHANNEL_REMAP, 8'h1b);
        acc(0, ADDR_CHANNEL_REMAP, 0);
        port_select = 4'h4;
        // every format code with a random map and every channel id
        for (f = 0; f < 4; f++) begin
            fmt = 2'(f);
            rnd = lfsr(rnd);
            acc(1, ADDR_CHANNEL_REMAP, rnd[7:0]);
            for (v = 0; v < 4; v++) put(v, 6'h2b, rnd);
            src_u.idle();
        end
        fmt = FMT_CSI2;
        // stats without freeze, then freeze, dropped frame and latching
        frame(3, 16'h0123);
        for (a = 8'h73; a <= 8'h76; a++) acc(0, a, 0);
        l_en = 1;
        w_en = 1;
        frame(5, 16'h0456);
        frame(6, 16'h0789);
        acc(0, 8'h73, 0);
        acc(0, 8'h75, 0);
        frame(300, 16'h1abc);
        for (a = 8'h74; a <= 8'h76; a += 2) acc(0, a, 0);
        for (a = 8'h73; a <= 8'h76; a++) acc(0, a, 0);
        repeat (30) @(negedge mclk);
        check("line events", 24'(sev[0]), 24'(nev[0]));
        check("width events", 24'(sev[1]), 24'(nev[1]));
        check("left over", 24'(exp_q.size()), 24'h00_0000);
        summarize();
    end
endmodule : rvs_rx_port_tb_top
`default_nettype wire
